/* File: hw/nvc_ctrl.sv */
// Nonvolatile memory read and write controller with Wishbone registers
//
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/1ps
module nvc_ctrl
  import nvc_pkg::*;
#(
  parameter int DATA_AW   = 7,
  parameter int PGM_AW    = 10,
  parameter int WRITE_CYC = NVC_WRITE_CYC
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] adr_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  // Memory port
  output logic             mem_rd_o,
  output logic             mem_wr_o,
  output logic             mem_pgm_o,
  output logic [12:0]      mem_addr_o,
  output logic [7:0]       mem_wdata_o,
  input  wire logic [13:0] mem_rdata_i,
  // Core stall for the ignored instruction
  output logic             core_skip_o,
  // Interrupt
  output logic             irq_o
);
  localparam int WCW = $clog2(WRITE_CYC + 1);
  localparam logic [WCW-1:0] WLAST = WCW'(WRITE_CYC - 1);

  initial begin
    if (DATA_AW < 1 || DATA_AW > 8) $error("nvc_ctrl: bad DATA_AW");
    if (PGM_AW < 1 || PGM_AW > 13) $error("nvc_ctrl: bad PGM_AW");
    if (WRITE_CYC < 1) $error("nvc_ctrl: bad WRITE_CYC");
  end

  nvc_wb_req_type  req;
  nvc_mem_req_type next_mem;
  nvc_state_type   state;
  nvc_unlock_type  unlock;

  logic [7:0]     data_low;
  logic [7:0]     data_high;
  logic [7:0]     addr_low;
  logic [7:0]     addr_high;
  logic           pgm_sel;
  logic           permit;
  logic           wr_bit;
  logic           rd_bit;
  logic           done_flag;
  logic           done_mask;
  logic [WCW-1:0] wcount;
  logic           tick;
  logic           bus_go;
  logic           bus_wr;
  logic [8:0]     idx;
  logic           lane0;
  logic           wr_ctl;
  logic           set_wr;
  logic           wr_end;
  logic           rd_done;

  nvc_divider #(
    .DIV (NVC_INSTR_CYC)
  ) u_div (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .tick_o (tick)
  );

  assign req    = '{cyc: cyc_i, stb: stb_i, we: we_i, sel: sel_i,
                    adr: adr_i, dat: dat_i};
  assign bus_go = req.cyc && req.stb && !ack_o;
  assign bus_wr = bus_go && req.we;
  assign idx    = req.adr[10:2];
  assign lane0  = req.sel[0];
  assign wr_ctl = bus_wr && lane0 && (idx == NVC_IDX_CONTROL);
  // Write starts only from a fully unlocked sequence with permit set
  assign set_wr = wr_ctl && req.dat[NVC_CTL_WRITE] && !wr_bit
                  && (state == NVC_IDLE) && (unlock == NVC_KEY2_OK)
                  && permit;
  assign wr_end = (state == NVC_WRITING) && (wcount == WLAST);
  // Capture only once the read strobe and settled address have stood
  assign rd_done = tick && mem_rd_o && ((state == NVC_RD_DATA) ||
                                        (state == NVC_RD_PGM2));

  // Wishbone ack, one cycle after request, dropped next cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) ack_o <= 1'b0;
    else ack_o <= bus_go;
  end

  // Read data mux
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (bus_go && !req.we) begin
      if (idx == NVC_IDX_DATA_LOW) dat_o <= {24'h00_0000, data_low};
      else if (idx == NVC_IDX_DATA_HIGH)
        dat_o <= {24'h00_0000, data_high};
      else if (idx == NVC_IDX_ADDR_LOW)
        dat_o <= {24'h00_0000, addr_low};
      else if (idx == NVC_IDX_ADDR_HIGH)
        dat_o <= {24'h00_0000, addr_high};
      else if (idx == NVC_IDX_CONTROL)
        dat_o <= {24'h00_0000, pgm_sel, 4'h0, permit, wr_bit, rd_bit};
      else if (idx == NVC_IDX_IRQ_STAT)
        dat_o <= {31'h0000_0000, done_flag};
      else if (idx == NVC_IDX_IRQ_MASK)
        dat_o <= {31'h0000_0000, done_mask};
      else dat_o <= 32'h0000_0000;
    end
  end

  // Address registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr_low  <= 8'h00;
      addr_high <= 8'h00;
    end else if (bus_wr && lane0) begin
      if (idx == NVC_IDX_ADDR_LOW) addr_low <= req.dat[7:0];
      else if (idx == NVC_IDX_ADDR_HIGH) addr_high <= req.dat[7:0];
    end
  end

  // Data registers: loaded by reads, or by software for a write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_low  <= 8'h00;
      data_high <= 8'h00;
    end else if (rd_done) begin
      data_low <= mem_rdata_i[7:0];
      if (state == NVC_RD_PGM2)
        data_high <= {2'b00, mem_rdata_i[13:8]};
    end else if (bus_wr && lane0) begin
      if (idx == NVC_IDX_DATA_LOW) data_low <= req.dat[7:0];
      else if (idx == NVC_IDX_DATA_HIGH) data_high <= req.dat[7:0];
    end
  end

  // Control bits; permit only ever written by software
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pgm_sel <= 1'b0;
      permit  <= 1'b0;
    end else if (wr_ctl) begin
      pgm_sel <= req.dat[NVC_CTL_PGM_SEL];
      permit  <= req.dat[NVC_CTL_PERMIT];
    end
  end

  // Unlock sequence tracker; any other write to the block breaks it, reads do not
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      unlock <= NVC_LOCKED;
    end else if (bus_wr && lane0 && idx == NVC_IDX_UNLOCK) begin
      if (req.dat[7:0] == NVC_KEY_FIRST && unlock == NVC_LOCKED)
        unlock <= NVC_KEY1_OK;
      else if (req.dat[7:0] == NVC_KEY_SECOND && unlock == NVC_KEY1_OK)
        unlock <= NVC_KEY2_OK;
      else unlock <= NVC_LOCKED;
    end else if (bus_wr) begin
      unlock <= NVC_LOCKED;
    end
  end

  // Sequencer for reads and writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state  <= NVC_IDLE;
      rd_bit <= 1'b0;
      wr_bit <= 1'b0;
      wcount <= '0;
    end else begin
      case (state)
        NVC_IDLE: begin
          wcount <= '0;
          if (set_wr) begin
            wr_bit <= 1'b1;
            state  <= NVC_WRITING;
          end else if (wr_ctl && req.dat[NVC_CTL_READ]) begin
            rd_bit <= 1'b1;
            state  <= req.dat[NVC_CTL_PGM_SEL] ? NVC_RD_PGM1
                                               : NVC_RD_DATA;
          end
        end
        NVC_RD_DATA: begin
          if (tick && mem_rd_o) begin
            rd_bit <= 1'b0;
            state  <= NVC_IDLE;
          end
        end
        NVC_RD_PGM1: begin
          if (tick) state <= NVC_RD_PGM2;
        end
        NVC_RD_PGM2: begin
          if (tick) begin
            rd_bit <= 1'b0;
            state  <= NVC_IDLE;
          end
        end
        NVC_WRITING: begin
          // Permit is not looked at here
          wcount <= wcount + WCW'(1);
          if (wr_end) begin
            wr_bit <= 1'b0;
            state  <= NVC_IDLE;
          end
        end
        default: state <= NVC_IDLE;
      endcase
    end
  end

  // Memory port requests
  always_comb begin
    next_mem       = '0;
    next_mem.pgm   = pgm_sel;
    next_mem.addr  = pgm_sel ? 13'({addr_high, addr_low}) &
                               13'((1 << PGM_AW) - 1)
                             : 13'(addr_low) & 13'((1 << DATA_AW) - 1);
    next_mem.wdata = data_low;
    next_mem.rd    = (state == NVC_RD_DATA) || (state == NVC_RD_PGM2);
    next_mem.wr    = wr_end;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_rd_o    <= 1'b0;
      mem_wr_o    <= 1'b0;
      mem_pgm_o   <= 1'b0;
      mem_addr_o  <= 13'h0000;
      mem_wdata_o <= 8'h00;
      core_skip_o <= 1'b0;
    end else begin
      mem_rd_o    <= next_mem.rd;
      mem_wr_o    <= next_mem.wr;
      mem_pgm_o   <= next_mem.pgm;
      mem_addr_o  <= next_mem.addr;
      mem_wdata_o <= next_mem.wdata;
      core_skip_o <= (state == NVC_RD_PGM2);
    end
  end

  // Done flag: set wins over write-one-to-clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_flag <= 1'b0;
      done_mask <= 1'b0;
    end else begin
      if (wr_end) done_flag <= 1'b1;
      else if (bus_wr && lane0 && idx == NVC_IDX_IRQ_STAT &&
               req.dat[NVC_IRQ_DONE])
        done_flag <= 1'b0;
      if (bus_wr && lane0 && idx == NVC_IDX_IRQ_MASK)
        done_mask <= req.dat[NVC_IRQ_DONE];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) irq_o <= 1'b0;
    else irq_o <= done_flag && done_mask;
  end

  a_write_locked: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(wr_bit) |-> $past(permit) && $past(unlock == NVC_KEY2_OK))
    else $error("write started without unlock or permit");
  a_permit_blocks: assert property (@(posedge clk_i) disable iff (rst_i)
    !permit && !wr_bit |=> !wr_bit)
    else $error("write bit set while permit clear");
  a_permit_kept: assert property (@(posedge clk_i) disable iff (rst_i)
    !wr_ctl |=> $stable(permit))
    else $error("permit changed without software");
  a_write_runs: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(wr_bit) |-> wr_bit [*8])
    else $error("write aborted early");
  a_write_done: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(wr_bit) |-> done_flag && mem_wr_o)
    else $error("write end without flag");
  a_data_read: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(rd_bit) && !pgm_sel |-> ##[1:8] !rd_bit)
    else $error("data read too slow");
  a_data_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !rd_done && !(bus_wr && idx == NVC_IDX_DATA_LOW) |=> $stable(data_low))
    else $error("data low changed unexpectedly");
  a_pgm_skip: assert property (@(posedge clk_i) disable iff (rst_i)
    state == NVC_RD_PGM1 && tick |=> ##1 core_skip_o)
    else $error("ignored instruction not signalled");
  a_pgm_word: assert property (@(posedge clk_i) disable iff (rst_i)
    state == NVC_RD_PGM2 && tick |=>
      data_high == {2'b00, $past(mem_rdata_i[13:8])})
    else $error("program high byte wrong");
  a_read_clears: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_done |=> !rd_bit)
    else $error("read bit not cleared");
endmodule : nvc_ctrl

/* File: hw/nvc_divider.sv */
// Instruction cycle enable divider
`timescale 1ns/1ps
module nvc_divider
  import nvc_pkg::*;
#(
  parameter int DIV = NVC_INSTR_CYC
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Enable pulse
  output logic      tick_o
);
  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] count;

  initial begin
    if (DIV < 1) $error("nvc_divider: DIV must be at least 1");
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count  <= '0;
      tick_o <= 1'b0;
    end else begin
      tick_o <= (count == LAST);
      if (count == LAST) count <= '0;
      else count <= count + CW'(1);
    end
  end
endmodule : nvc_divider

/* File: hw/nvc_pkg.sv */
// Package: register map, control fields and timing for the nv controller
package nvc_pkg;
  // Register offsets (index; byte address is four times the index)
  localparam logic [8:0] NVC_IDX_DATA_LOW  = 9'h10C;
  localparam logic [8:0] NVC_IDX_ADDR_LOW  = 9'h10D;
  localparam logic [8:0] NVC_IDX_DATA_HIGH = 9'h10E;
  localparam logic [8:0] NVC_IDX_ADDR_HIGH = 9'h10F;
  localparam logic [8:0] NVC_IDX_CONTROL   = 9'h18C;
  localparam logic [8:0] NVC_IDX_UNLOCK    = 9'h18D;
  localparam logic [8:0] NVC_IDX_IRQ_STAT  = 9'h190;
  localparam logic [8:0] NVC_IDX_IRQ_MASK  = 9'h191;

  // Control register fields
  localparam int NVC_CTL_PGM_SEL = 7;
  localparam int NVC_CTL_PERMIT  = 2;
  localparam int NVC_CTL_WRITE   = 1;
  localparam int NVC_CTL_READ    = 0;

  // Status and mask fields
  localparam int NVC_IRQ_DONE = 0;

  // Unlock keys
  localparam logic [7:0] NVC_KEY_FIRST  = 8'h55;
  localparam logic [7:0] NVC_KEY_SECOND = 8'hAA;

  // Instruction cycle is four core clocks of 25 ns
  localparam int NVC_CLK_NS      = 25;
  localparam int NVC_INSTR_NS    = 100;
  localparam int NVC_INSTR_CYC   = (NVC_INSTR_NS + NVC_CLK_NS - 1)
                                   / NVC_CLK_NS;
  // Nominal data write time in microseconds
  localparam int NVC_WRITE_US    = 4000;
  localparam int NVC_WRITE_CYC   = NVC_WRITE_US * 1000 / NVC_CLK_NS;

  typedef enum logic [2:0] {
    NVC_IDLE     = 3'b000,
    NVC_RD_DATA  = 3'b001,
    NVC_RD_PGM1  = 3'b011,
    NVC_RD_PGM2  = 3'b010,
    NVC_WRITING  = 3'b110
  } nvc_state_type;

  typedef enum logic [1:0] {
    NVC_LOCKED   = 2'b00,
    NVC_KEY1_OK  = 2'b01,
    NVC_KEY2_OK  = 2'b11
  } nvc_unlock_type;

  // Memory port request
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic        pgm;
    logic [12:0] addr;
    logic [7:0]  wdata;
  } nvc_mem_req_type;

  // Wishbone request as seen by the slave
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [31:0] adr;
    logic [31:0] dat;
  } nvc_wb_req_type;
endpackage : nvc_pkg

/* File: verification/test_nvc_ctrl.sv */
// Self-checking testbench for the nv memory read and write controller
`timescale 1ns/1ps
module test_nvc_ctrl
  import nvc_pkg::*;
();
  localparam int WCYC   = 20;
  localparam int CEIL   = 4000;
  localparam int N_ROWS = 7;
  // Rows: register index, write byte, expected read byte
  localparam logic [24:0] ROWS [N_ROWS] = '{
    {NVC_IDX_ADDR_LOW, 8'hA5, 8'hA5},
    {NVC_IDX_ADDR_HIGH, 8'h03, 8'h03},
    {NVC_IDX_DATA_LOW, 8'h5C, 8'h5C},
    {NVC_IDX_DATA_HIGH, 8'h15, 8'h15},
    {NVC_IDX_IRQ_MASK, 8'h01, 8'h01},
    {NVC_IDX_CONTROL, 8'h84, 8'h84},
    {9'h1FF, 8'h77, 8'h00}
  };

  logic        clk_i;
  logic        rst_i;
  logic        cyc_i;
  logic        stb_i;
  logic        we_i;
  logic [3:0]  sel_i;
  logic [31:0] adr_i;
  logic [31:0] dat_i;
  logic [31:0] dat_o;
  logic        ack_o;
  logic        mem_rd_o;
  logic        mem_wr_o;
  logic        mem_pgm_o;
  logic [12:0] mem_addr_o;
  logic [7:0]  mem_wdata_o;
  logic [13:0] mem_rdata_i;
  logic        core_skip_o;
  logic        irq_o;
  logic [31:0] rdat;
  logic [12:0] wr_addr;
  logic [7:0]  wr_data;
  logic [13:0] pw;
  int          bad_count;
  int          total_checks;
  int          cycles   = 0;
  int          skip_cnt = 0;
  int          wr_cnt   = 0;
  int          s0;
  int          w0;

  nvc_ctrl #(.WRITE_CYC(WCYC)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .sel_i(sel_i), .adr_i(adr_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .mem_rd_o(mem_rd_o),
    .mem_wr_o(mem_wr_o), .mem_pgm_o(mem_pgm_o), .mem_addr_o(mem_addr_o),
    .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i),
    .core_skip_o(core_skip_o), .irq_o(irq_o)
  );

  function automatic logic [13:0] mem_f(input logic [12:0] a);
    return {1'b0, a} ^ 14'h2A5A;
  endfunction : mem_f

  // Memory answers in the same clock as the address
  assign mem_rdata_i = mem_f(mem_addr_o);

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // Cycle counter, time limit and event monitors
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (core_skip_o === 1'b1) skip_cnt <= skip_cnt + 1;
    if (mem_wr_o === 1'b1) begin
      wr_cnt  <= wr_cnt + 1;
      wr_addr <= mem_addr_o;
      wr_data <= mem_wdata_o;
    end
    if (cycles == CEIL) begin
      bad_count = bad_count + 1;
      wrap_up();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks = total_checks + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic wb(input logic [8:0] idx, input logic w,
                    input logic [7:0] wd);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    sel_i <= 4'h1;
    adr_i <= {21'h0, idx, 2'b00};
    dat_i <= {24'h0, wd};
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    rdat = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task automatic rd_chk(input logic [8:0] idx, input logic [7:0] exp);
    wb(idx, 1'b0, 8'h00);
    check(rdat, {24'h0, exp});
  endtask : rd_chk

  task automatic unlock_go(input logic [7:0] k1, input logic [7:0] k2,
                           input logic [7:0] ctl);
    wb(NVC_IDX_UNLOCK, 1'b1, k1);
    wb(NVC_IDX_UNLOCK, 1'b1, k2);
    wb(NVC_IDX_CONTROL, 1'b1, ctl);
  endtask : unlock_go

  task automatic wait_irq();
    int n;
    n = 0;
    while (irq_o !== 1'b1 && n < 100) begin
      @(posedge clk_i);
      n = n + 1;
    end
    check({31'h0, irq_o}, 32'h1);
  endtask : wait_irq

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  initial begin
    bad_count = 0;
    total_checks = 0;
    rst_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    sel_i = 4'h0;
    adr_i = 32'h0;
    dat_i = 32'h0;
    repeat (12) @(posedge clk_i);
    check({30'h0, irq_o, ack_o}, 32'h0);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd_chk(NVC_IDX_CONTROL, 8'h00);
    for (int i = 0; i < N_ROWS; i++) begin
      wb(ROWS[i][24:16], 1'b1, ROWS[i][15:8]);
      rd_chk(ROWS[i][24:16], ROWS[i][7:0]);
    end
    // Data byte read, then the held value survives an address change
    wb(NVC_IDX_ADDR_LOW, 1'b1, 8'h12);
    wb(NVC_IDX_CONTROL, 1'b1, 8'h01);
    repeat (8) @(posedge clk_i);
    rd_chk(NVC_IDX_CONTROL, 8'h00);
    pw = mem_f(13'h0012);
    rd_chk(NVC_IDX_DATA_LOW, pw[7:0]);
    wb(NVC_IDX_ADDR_LOW, 1'b1, 8'h40);
    rd_chk(NVC_IDX_DATA_LOW, pw[7:0]);
    // Program word read with one ignored instruction cycle
    s0 = skip_cnt;
    wb(NVC_IDX_ADDR_HIGH, 1'b1, 8'h02);
    wb(NVC_IDX_ADDR_LOW, 1'b1, 8'h34);
    wb(NVC_IDX_CONTROL, 1'b1, 8'h81);
    repeat (12) @(posedge clk_i);
    check(skip_cnt - s0, NVC_INSTR_CYC);
    pw = mem_f(13'h0234);
    rd_chk(NVC_IDX_DATA_LOW, pw[7:0]);
    rd_chk(NVC_IDX_DATA_HIGH, {2'b00, pw[13:8]});
    rd_chk(NVC_IDX_CONTROL, 8'h80);
    // Refused write starts: no permit, keys swapped, keys interrupted
    w0 = wr_cnt;
    wb(NVC_IDX_DATA_LOW, 1'b1, 8'hC3);
    wb(NVC_IDX_ADDR_LOW, 1'b1, 8'h21);
    unlock_go(NVC_KEY_FIRST, NVC_KEY_SECOND, 8'h02);
    rd_chk(NVC_IDX_CONTROL, 8'h00);
    unlock_go(NVC_KEY_SECOND, NVC_KEY_FIRST, 8'h06);
    rd_chk(NVC_IDX_CONTROL, 8'h04);
    wb(NVC_IDX_UNLOCK, 1'b1, NVC_KEY_FIRST);
    wb(NVC_IDX_ADDR_LOW, 1'b1, 8'h21);
    unlock_go(NVC_KEY_SECOND, NVC_KEY_SECOND, 8'h06);
    repeat (WCYC + 4) @(posedge clk_i);
    check(wr_cnt - w0, 0);
    // Proper write with interrupt raised, masked and cleared
    wb(NVC_IDX_IRQ_MASK, 1'b1, 8'h01);
    rd_chk(NVC_IDX_CONTROL, 8'h04);
    unlock_go(NVC_KEY_FIRST, NVC_KEY_SECOND, 8'h06);
    rd_chk(NVC_IDX_CONTROL, 8'h06);
    wait_irq();
    rd_chk(NVC_IDX_CONTROL, 8'h04);
    check({8'(wr_cnt - w0), 3'b0, wr_addr, wr_data}, 32'h0100_21C3);
    rd_chk(NVC_IDX_IRQ_STAT, 8'h01);
    wb(NVC_IDX_IRQ_MASK, 1'b1, 8'h00);
    check({31'h0, irq_o}, 32'h0);
    rd_chk(NVC_IDX_IRQ_STAT, 8'h01);
    wb(NVC_IDX_IRQ_MASK, 1'b1, 8'h01);
    check({31'h0, irq_o}, 32'h1);
    wb(NVC_IDX_IRQ_STAT, 1'b1, 8'h01);
    rd_chk(NVC_IDX_IRQ_STAT, 8'h00);
    check({31'h0, irq_o}, 32'h0);
    rd_chk(NVC_IDX_DATA_LOW, 8'hC3);
    // Permit dropped mid-write must not stop the write
    wb(NVC_IDX_DATA_LOW, 1'b1, 8'h3C);
    unlock_go(NVC_KEY_FIRST, NVC_KEY_SECOND, 8'h06);
    wb(NVC_IDX_CONTROL, 1'b1, 8'h00);
    wait_irq();
    check({8'(wr_cnt - w0), 3'b0, wr_addr, wr_data}, 32'h0200_213C);
    rd_chk(NVC_IDX_CONTROL, 8'h00);
    wrap_up();
  end
endmodule : test_nvc_ctrl
